/* File: hw/msh_map.svh */
// Notes on behaviour
// - A media insertion is reported to the host once; later commands do not repeat it.
// - In ATA mode an insertion sets the media-changed flag, error register bit 5.
// - In ATA mode a removal sets the no-media flag, error register bit 1.
// - In ATAPI mode an insertion yields sense key 06h with additional sense code 28h.
// - In ATAPI mode a removal yields sense key 02h with additional sense code 3Ah.
// - GET MEDIA STATUS ends normally with media present and no change pending, else with error and a media flag.
// - A failing ATA read or write leaves the same error register flags as GET MEDIA STATUS.
// - TEST UNIT READY ends normally with media present and no change pending; on error the host fetches sense data.
// - A failing ATAPI read or write yields the same sense codes as TEST UNIT READY.
// - Sleep with an accepted storage device attached keeps bus power on and only suspends the bus.
// - Sleep with no storage device attached switches bus power off.
// - The too-many-devices error rises when the third or a later device attaches.
// - No compliance error changes either card-detect output.
// - Devices that NAK without end or return a malformed status wrapper are refused.
// - The interrupt request is a level that signals status register changes.
`ifndef MSH_MAP_SVH
`define MSH_MAP_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define MSH_OFS_CTRL   8'h00
`define MSH_OFS_CMD    8'h04
`define MSH_OFS_STATUS 8'h08
`define MSH_OFS_ERROR  8'h0C
`define MSH_OFS_SENSE  8'h10
`define MSH_OFS_PORT   8'h14
// ----------------------------------------
// Fields, codes and reset values
// ----------------------------------------
`define MSH_ERR_MC_BIT    5
`define MSH_ERR_NM_BIT    1
`define MSH_ST_ERR_BIT    0
`define MSH_ST_RDY_BIT    6
`define MSH_ST_BSY_BIT    7
`define MSH_STATUS_RST    8'h50
`define MSH_KEY_CHANGE    4'h6
`define MSH_ASC_CHANGE    8'h28
`define MSH_KEY_NOT_READY 4'h2
`define MSH_ASC_NO_MEDIA  8'h3A
`define MSH_CMD_GMS       8'h01
`define MSH_CMD_TUR       8'h02
`define MSH_CMD_SENSE     8'h03
`define MSH_CMD_READ      8'h04
`define MSH_CMD_WRITE     8'h05
`define MSH_CMD_SLEEP     8'h06
`define MSH_DEV_LIMIT     3'h3
`endif

/* File: hw/msh_pkg.sv */
package msh_pkg;
    // Command engine states
    typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_POST} msh_state_t;
    // Sense data pair
    typedef struct packed {
        logic [3:0] key;
        logic [7:0] additional_sense_code;
    } msh_sense_t;
    // Compliance error outputs
    typedef struct packed {
        logic unsup;
        logic devs;
        logic hubs;
    } msh_comp_t;
endpackage : msh_pkg

/* File: hw/msh_top.sv */
// Our own choices: the placing of the registers and the Wishbone register port.
`timescale 1ns/10ps
`default_nettype none
`include "msh_map.svh"
module msh_top (
    input  wire logic              CLK_SYS,
    input  wire logic              RESETN,
    input  wire logic              WB_CYC_I,
    input  wire logic              WB_STB_I,
    input  wire logic              WB_WE_I,
    input  wire logic [7:0]        WB_ADR_I,
    input  wire logic [3:0]        WB_SEL_I,
    input  wire logic [31:0]       WB_DAT_I,
    output logic [31:0]            WB_DAT_O,
    output logic                   WB_ACK_O,
    input  wire logic              MEDIA_PRESENT,
    input  wire logic              STORAGE_PRESENT,
    input  wire logic              DEV_ATTACH,
    input  wire logic              DEV_DETACH,
    input  wire logic              DEV_UNSUPPORTED,
    input  wire logic              HUB_LIMIT,
    input  wire logic              DEV_REFUSE,
    output logic                   BUS_POWER_ENABLE,
    output logic                   BUS_SUSPEND,
    output logic                   CARD_DETECT_OUT_A_N,
    output logic                   CARD_DETECT_OUT_B_N,
    output msh_pkg::msh_comp_t     COMPLIANCE_ERR,
    output logic                   HOST_INTERRUPT_REQUEST
);
    import msh_pkg::*;

    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    // Used by both the read mux and the write strobes
    function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
        hit = (adr == ofs);
    endfunction : hit

    // ----------------------------------------
    // State
    // ----------------------------------------
    // Bus reply: one-cycle ack and the word read with it
    logic        ack_r, ack_nxt;
    logic [31:0] dat_r, dat_nxt;
    // Pin synchronisers and the last settled media level
    logic        med_s1_r, med_s2_r, med_prev_r;
    logic        sto_s1_r, sto_s2_r;
    // Mode and command engine
    logic        atapi_r, atapi_nxt;
    msh_state_t  state_r, state_nxt;
    logic [7:0]  cmd_r, cmd_nxt;
    logic [7:0]  status_r, status_nxt;
    logic [7:0]  error_r, error_nxt;
    msh_sense_t  sense_r, sense_nxt;
    // Sense waiting for REQUEST SENSE; the visible copy moves only then
    msh_sense_t  spend_r, spend_nxt;
    logic        mc_pend_r, mc_pend_nxt;
    logic        refused_r, refused_nxt;
    // Downstream port power, suspend and compliance state
    logic        pwr_r, pwr_nxt;
    logic        susp_r, susp_nxt;
    logic        irq_r, irq_nxt;
    logic [2:0]  cnt_r, cnt_nxt;
    msh_comp_t   comp_r, comp_nxt;
    logic        cda_r, cda_nxt;
    logic        cdb_r, cdb_nxt;

    // ----------------------------------------
    // Derived terms
    // ----------------------------------------
    logic wr_go, rd_go, med_ok, sto_ok, ins, rem, media_cmd;

    // Bus strobes fire in the ack cycle, where a write takes effect
    assign wr_go     = WB_CYC_I & WB_STB_I & WB_WE_I & ack_r;
    assign rd_go     = WB_CYC_I & WB_STB_I & ~WB_WE_I & ack_r;

    // Media counts as usable only behind an accepted storage device
    assign sto_ok    = sto_s2_r & ~refused_r;
    assign med_ok    = med_s2_r & sto_ok;

    // Edges of the settled media pin; prev resets low, so media
    // already present at reset is reported once as an insertion
    assign ins       = med_s2_r & ~med_prev_r;
    assign rem       = ~med_s2_r & med_prev_r;

    // Commands that touch the media and so report its state
    assign media_cmd = (cmd_r == `MSH_CMD_GMS) | (cmd_r == `MSH_CMD_TUR) |
                       (cmd_r == `MSH_CMD_READ) | (cmd_r == `MSH_CMD_WRITE);

    // ----------------------------------------
    // Next-state logic
    // ----------------------------------------
    always_comb begin
        ack_nxt     = WB_CYC_I & WB_STB_I & ~ack_r;
        dat_nxt     = 32'h0000_0000;
        atapi_nxt   = atapi_r;
        state_nxt   = state_r;
        cmd_nxt     = cmd_r;
        status_nxt  = status_r;
        error_nxt   = error_r;
        sense_nxt   = sense_r;
        spend_nxt   = spend_r;
        mc_pend_nxt = mc_pend_r;
        refused_nxt = refused_r;
        pwr_nxt     = pwr_r;
        susp_nxt    = susp_r;
        irq_nxt     = irq_r;
        cnt_nxt     = cnt_r;
        comp_nxt    = comp_r;

        // Read data captured one edge early so it is valid with ack
        // Only a read being taken loads it: the bus shows zero outside
        // ack, and an address left standing cannot leak a register
        if (WB_CYC_I & WB_STB_I & ~WB_WE_I & ~ack_r) begin
            if (hit(WB_ADR_I, `MSH_OFS_CTRL)) begin
                dat_nxt[0] = atapi_r;
            end else if (hit(WB_ADR_I, `MSH_OFS_STATUS)) begin
                dat_nxt[7:0] = status_r;
            end else if (hit(WB_ADR_I, `MSH_OFS_ERROR)) begin
                dat_nxt[7:0] = error_r;
            end else if (hit(WB_ADR_I, `MSH_OFS_SENSE)) begin
                dat_nxt[15:0] = {sense_r.additional_sense_code, 4'h0, sense_r.key};
            end else if (hit(WB_ADR_I, `MSH_OFS_PORT)) begin
                dat_nxt[9:0] = {cnt_r, comp_r, med_ok, sto_ok, susp_r, pwr_r};
            end
        end

        // Mode control
        if (wr_go & WB_SEL_I[0] & hit(WB_ADR_I, `MSH_OFS_CTRL)) begin
            atapi_nxt = WB_DAT_I[0];
        end

        // Reading status acknowledges the interrupt, as on an ATA port
        if (rd_go & hit(WB_ADR_I, `MSH_OFS_STATUS)) begin
            irq_nxt = 1'b0;
        end

        // Refusal holds until the storage device goes away
        if (!sto_s2_r) begin
            refused_nxt = 1'b0;
        end
        if (DEV_REFUSE) begin
            refused_nxt = 1'b1;
        end

        // Removal cancels a pending change; insertion sets it
        if (rem) begin
            mc_pend_nxt = 1'b0;
        end

        // Command engine
        case (state_r)
            ST_IDLE: begin
                // Commands written while busy are dropped
                if (wr_go & WB_SEL_I[0] & hit(WB_ADR_I, `MSH_OFS_CMD)) begin
                    cmd_nxt    = WB_DAT_I[7:0];
                    status_nxt = 8'h00;
                    status_nxt[`MSH_ST_BSY_BIT] = 1'b1;
                    state_nxt  = ST_EXEC;
                end
            end
            ST_EXEC: begin
                status_nxt = 8'h00;
                status_nxt[`MSH_ST_RDY_BIT] = 1'b1;
                error_nxt  = 8'h00;
                pwr_nxt    = 1'b1;
                susp_nxt   = 1'b0;
                if (cmd_r == `MSH_CMD_SLEEP) begin
                    if (sto_ok) begin
                        susp_nxt = 1'b1;
                    end else begin
                        pwr_nxt  = 1'b0;
                    end
                end else if (cmd_r == `MSH_CMD_SENSE) begin
                    // Hand over the latched sense and consume it
                    sense_nxt = spend_r;
                    spend_nxt = '0;
                    // No media is tested first, so it beats a pending change
                end else if (media_cmd & !med_ok) begin
                    status_nxt[`MSH_ST_ERR_BIT] = 1'b1;
                    if (atapi_r) begin
                        spend_nxt = '{key: `MSH_KEY_NOT_READY, additional_sense_code: `MSH_ASC_NO_MEDIA};
                    end else begin
                        error_nxt[`MSH_ERR_NM_BIT] = 1'b1;
                    end
                end else if (media_cmd & mc_pend_r) begin
                    status_nxt[`MSH_ST_ERR_BIT] = 1'b1;
                    mc_pend_nxt = 1'b0;
                    if (atapi_r) begin
                        spend_nxt = '{key: `MSH_KEY_CHANGE, additional_sense_code: `MSH_ASC_CHANGE};
                    end else begin
                        error_nxt[`MSH_ERR_MC_BIT] = 1'b1;
                    end
                end
                // Read and write share the same checks above
                state_nxt = ST_POST;
            end
            ST_POST: begin
                // Status settled last edge, so error precedes interrupt
                irq_nxt   = 1'b1;
                state_nxt = ST_IDLE;
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase

        // An insertion in the very cycle of a report stays pending
        if (ins) begin
            mc_pend_nxt = 1'b1;
        end

        // Downstream device count saturates at seven
        // Attach and detach in one cycle cancel each other out
        if (DEV_ATTACH & ~DEV_DETACH & (cnt_r != 3'h7)) begin
            cnt_nxt = cnt_r + 3'h1;
        end else if (DEV_DETACH & ~DEV_ATTACH & (cnt_r != 3'h0)) begin
            cnt_nxt = cnt_r - 3'h1;
        end

        // Compliance errors; latched ones clear when the port empties
        // Device count error follows the count itself, so it drops
        // as soon as fewer than three devices remain, with no software clear needed
        comp_nxt.devs = (cnt_nxt >= `MSH_DEV_LIMIT);
        if (cnt_r == 3'h0) begin
            comp_nxt.unsup = 1'b0;
            comp_nxt.hubs  = 1'b0;
        end
        if (DEV_UNSUPPORTED) begin
            comp_nxt.unsup = 1'b1;
        end
        if (HUB_LIMIT) begin
            comp_nxt.hubs = 1'b1;
        end
    end

    // Card detect follows media and accepted storage only, never compliance
    assign cda_nxt = ~med_ok;
    assign cdb_nxt = ~sto_ok;

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge CLK_SYS) begin
        // Pins pass two flops before use
        // Kept outside the reset so they flush while reset is held
        med_s1_r <= MEDIA_PRESENT;
        med_s2_r <= med_s1_r;
        sto_s1_r <= STORAGE_PRESENT;
        sto_s2_r <= sto_s1_r;
        if (!RESETN) begin
            med_prev_r <= 1'b0;
            ack_r      <= 1'b0;
            dat_r      <= 32'h0000_0000;
            atapi_r    <= 1'b0;
            state_r    <= ST_IDLE;
            cmd_r      <= 8'h00;
            status_r   <= `MSH_STATUS_RST;
            error_r    <= 8'h00;
            sense_r    <= '0;
            spend_r    <= '0;
            mc_pend_r  <= 1'b0;
            refused_r  <= 1'b0;
            pwr_r      <= 1'b1;
            susp_r     <= 1'b0;
            irq_r      <= 1'b0;
            cnt_r      <= 3'h0;
            comp_r     <= '0;
            cda_r      <= 1'b1;
            cdb_r      <= 1'b1;
        end else begin
            med_prev_r <= med_s2_r;
            ack_r      <= ack_nxt;
            dat_r      <= dat_nxt;
            atapi_r    <= atapi_nxt;
            state_r    <= state_nxt;
            cmd_r      <= cmd_nxt;
            status_r   <= status_nxt;
            error_r    <= error_nxt;
            sense_r    <= sense_nxt;
            spend_r    <= spend_nxt;
            mc_pend_r  <= mc_pend_nxt;
            refused_r  <= refused_nxt;
            pwr_r      <= pwr_nxt;
            susp_r     <= susp_nxt;
            irq_r      <= irq_nxt;
            cnt_r      <= cnt_nxt;
            comp_r     <= comp_nxt;
            cda_r      <= cda_nxt;
            cdb_r      <= cdb_nxt;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    // Every output comes straight from a flop, so no glitch leaves the block
    assign WB_ACK_O               = ack_r;
    assign WB_DAT_O               = dat_r;
    assign BUS_POWER_ENABLE       = pwr_r;
    assign BUS_SUSPEND            = susp_r;
    assign CARD_DETECT_OUT_A_N    = cda_r;
    assign CARD_DETECT_OUT_B_N    = cdb_r;
    assign COMPLIANCE_ERR         = comp_r;
    assign HOST_INTERRUPT_REQUEST = irq_r;
endmodule : msh_top
`default_nettype wire

/* File: test/msh_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
`include "msh_map.svh"
module msh_monitor (
    input wire logic               CLK_SYS,
    input wire logic               RESETN,
    input wire logic               WB_CYC_I,
    input wire logic               WB_STB_I,
    input wire logic               WB_WE_I,
    input wire logic [7:0]         WB_ADR_I,
    input wire logic [31:0]        WB_DAT_O,
    input wire logic               WB_ACK_O,
    input wire logic               STORAGE_PRESENT,
    input wire logic               DEV_ATTACH,
    input wire logic               DEV_DETACH,
    input wire logic               BUS_POWER_ENABLE,
    input wire logic               CARD_DETECT_OUT_A_N,
    input wire logic               CARD_DETECT_OUT_B_N,
    input wire msh_pkg::msh_comp_t COMPLIANCE_ERR,
    input wire logic               HOST_INTERRUPT_REQUEST
);
    import msh_pkg::*;
    // ----------------------------------------
    // Helper state
    // ----------------------------------------
    logic [2:0] cnt_r;
    logic [2:0] cnt_nxt;
    logic       cmdw;
    logic       strd;
    // Own device count, saturating like the design
    always_comb begin
        cnt_nxt = cnt_r;
        if (DEV_ATTACH && cnt_r != 3'h7) cnt_nxt = cnt_r + 3'h1;
        else if (DEV_DETACH && cnt_r != 3'h0) cnt_nxt = cnt_r - 3'h1;
    end
    always_ff @(posedge CLK_SYS) begin
        cnt_r <= RESETN ? cnt_nxt : 3'h0;
    end
    // Completed command write and status read
    assign cmdw = WB_ACK_O && WB_WE_I && WB_ADR_I == `MSH_OFS_CMD;
    assign strd = WB_ACK_O && !WB_WE_I && WB_ADR_I == `MSH_OFS_STATUS;
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RESETN);
    a_ack_single: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack longer than one cycle");
    a_ack_latency: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
        else $error("ack late");
    a_data_idle: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0000_0000)
        else $error("read data outside ack");
    a_irq_hold: assert property ($fell(HOST_INTERRUPT_REQUEST) |-> $past(strd))
        else $error("irq dropped without status read");
    a_irq_cause: assert property ($rose(HOST_INTERRUPT_REQUEST) |-> $past(cmdw, 2) || $past(cmdw, 3))
        else $error("irq without command");
    a_card_steady: assert property ($changed(COMPLIANCE_ERR) |->
        $stable(CARD_DETECT_OUT_A_N) && $stable(CARD_DETECT_OUT_B_N)) else $error("card detect moved");
    a_devs_third: assert property (DEV_ATTACH && cnt_r == 3'h2 |-> ##[1:2] COMPLIANCE_ERR.devs)
        else $error("third device not flagged");
    a_power_off: assert property ($fell(BUS_POWER_ENABLE) |-> !STORAGE_PRESENT)
        else $error("power cut with storage attached");
endmodule : msh_monitor
bind msh_top msh_monitor u_mon (.*);
`default_nettype wire

/* File: test/msh_far_model.sv */
`timescale 1ns/10ps
`default_nettype none
module msh_far_model (
    input  wire logic       clk,
    output var  logic       media,
    output var  logic       storage,
    output var  logic [4:0] ev
);
    // ----------------------------------------
    // Downstream pins and event pulses
    // ----------------------------------------
    // Nothing plugged at time zero
    initial begin
        media = 1'b0;
        storage = 1'b0;
        ev = 5'h00;
    end
    // Held long enough to pass the synchronisers
    task automatic plug(input logic m, input logic s);
        @(posedge clk);
        media <= m;
        storage <= s;
        repeat (5) @(posedge clk);
    endtask : plug
    // Bits: attach, detach, unsupported, hub, refuse
    task automatic pulse(input int i);
        @(posedge clk);
        ev <= 5'h01 << i;
        @(posedge clk);
        ev <= 5'h00;
        repeat (2) @(posedge clk);
    endtask : pulse
endmodule : msh_far_model
`default_nettype wire

/* File: test/tb_media_status_and_host_port_events.sv */
`timescale 1ns/10ps
`default_nettype none
`include "msh_map.svh"
`define MSH_CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin fails++; \
    $display("BAD %s exp %h got %h", n, e, g); end end
module tb_media_status_and_host_port_events;
    import msh_pkg::*;
    logic             clk_sys = 1'b0;
    logic             resetn = 1'b0;
    logic             cyc = 1'b0;
    logic             stb = 1'b0;
    logic             we = 1'b0;
    logic [7:0]       adr = 8'h00;
    logic [31:0]      wdat = 32'h0000_0000;
    logic [31:0]      rdat;
    logic [31:0]      q;
    logic [3:0]       sel = 4'h0;
    logic [3:0]       lanes = 4'hF;
    logic             ack, media, storage, pwr, susp, cda_n, cdb_n, irq;
    logic [4:0]       ev;
    msh_comp_t        comp;
    int               fails = 0;
    int               total_checks = 0;
    // 100 MHz system clock
    always #5 clk_sys = ~clk_sys;
    msh_top dut (
        .CLK_SYS(clk_sys), .RESETN(resetn), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
        .MEDIA_PRESENT(media), .STORAGE_PRESENT(storage), .DEV_ATTACH(ev[0]), .DEV_DETACH(ev[1]),
        .DEV_UNSUPPORTED(ev[2]), .HUB_LIMIT(ev[3]), .DEV_REFUSE(ev[4]), .BUS_POWER_ENABLE(pwr),
        .BUS_SUSPEND(susp), .CARD_DETECT_OUT_A_N(cda_n), .CARD_DETECT_OUT_B_N(cdb_n),
        .COMPLIANCE_ERR(comp), .HOST_INTERRUPT_REQUEST(irq));
    msh_far_model far (.clk(clk_sys), .media(media), .storage(storage), .ev(ev));
    // ----------------------------------------
    // Bus and command tasks
    // ----------------------------------------
    // Classic cycle, request held until ack is sampled
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        @(posedge clk_sys);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= lanes;
        do begin
            @(posedge clk_sys);
            n++;
        end while (ack !== 1'b1 && n < 40);
        r = rdat;
        if (n >= 40) fails++;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        sel <= 4'h0;
    endtask : xfer
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string nm);
        logic [31:0] r;
        xfer(1'b0, a, 32'h0000_0000, r);
        `MSH_CHK(nm, e, r)
    endtask : rd_chk
    // Level interrupt must wait until status is read
    task automatic cmd(input logic [7:0] c, input logic [7:0] st, input logic [7:0] er);
        logic [31:0] r;
        int n;
        xfer(1'b1, `MSH_OFS_CMD, {24'h00_0000, c}, r);
        n = 0;
        while (irq !== 1'b1 && n < 10) begin
            @(posedge clk_sys);
            n++;
        end
        `MSH_CHK("irq", 1'b1, irq)
        rd_chk(`MSH_OFS_STATUS, {24'h00_0000, st}, "status");
        rd_chk(`MSH_OFS_ERROR, {24'h00_0000, er}, "error");
        `MSH_CHK("irq clear", 1'b0, irq)
    endtask : cmd
    task automatic sense(input logic [7:0] additional_sense_code, input logic [3:0] key);
        cmd(`MSH_CMD_SENSE, 8'h40, 8'h00);
        rd_chk(`MSH_OFS_SENSE, {16'h0000, additional_sense_code, 4'h0, key}, "sense");
    endtask : sense
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : give_verdict
    // Hang guard, far beyond the expected run
    initial begin
        repeat (20000) @(posedge clk_sys);
        fails++;
        give_verdict();
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (8) @(posedge clk_sys);
        resetn <= 1'b1;
        xfer(1'b1, `MSH_OFS_STATUS, 32'h0000_00FF, q);
        xfer(1'b1, 8'h20, 32'h0000_00FF, q);
        rd_chk(`MSH_OFS_STATUS, 32'h0000_0050, "status rst");
        rd_chk(8'h20, 32'h0000_0000, "unmapped");
        `MSH_CHK("power rst", 1'b1, pwr)
        cmd(`MSH_CMD_GMS, 8'h41, 8'h02);
        far.plug(1'b1, 1'b1);
        `MSH_CHK("card a", 1'b0, cda_n)
        cmd(`MSH_CMD_GMS, 8'h41, 8'h20);
        cmd(`MSH_CMD_GMS, 8'h40, 8'h00);
        far.plug(1'b0, 1'b1);
        cmd(`MSH_CMD_READ, 8'h41, 8'h02);
        far.plug(1'b1, 1'b1);
        cmd(`MSH_CMD_WRITE, 8'h41, 8'h20);
        cmd(`MSH_CMD_READ, 8'h40, 8'h00);
        // Sense based reporting
        xfer(1'b1, `MSH_OFS_CTRL, 32'h0000_0001, q);
        // Mode write without lane 0 must leave ATAPI mode in place
        lanes = 4'hE;
        xfer(1'b1, `MSH_OFS_CTRL, 32'h0000_0000, q);
        lanes = 4'hF;
        rd_chk(`MSH_OFS_CTRL, 32'h0000_0001, "mode lanes");
        far.plug(1'b0, 1'b1);
        cmd(`MSH_CMD_TUR, 8'h41, 8'h00);
        sense(`MSH_ASC_NO_MEDIA, `MSH_KEY_NOT_READY);
        far.plug(1'b1, 1'b1);
        cmd(`MSH_CMD_TUR, 8'h41, 8'h00);
        sense(`MSH_ASC_CHANGE, `MSH_KEY_CHANGE);
        cmd(`MSH_CMD_TUR, 8'h40, 8'h00);
        far.plug(1'b0, 1'b1);
        cmd(`MSH_CMD_WRITE, 8'h41, 8'h00);
        sense(`MSH_ASC_NO_MEDIA, `MSH_KEY_NOT_READY);
        far.plug(1'b1, 1'b1);
        cmd(`MSH_CMD_READ, 8'h41, 8'h00);
        sense(`MSH_ASC_CHANGE, `MSH_KEY_CHANGE);
        // Sleep with and without storage
        cmd(`MSH_CMD_SLEEP, 8'h40, 8'h00);
        `MSH_CHK("suspend", 2'h3, {pwr, susp})
        far.plug(1'b1, 1'b0);
        cmd(`MSH_CMD_SLEEP, 8'h40, 8'h00);
        `MSH_CHK("power off", 1'b0, pwr)
        cmd(`MSH_CMD_TUR, 8'h41, 8'h00);
        `MSH_CHK("power back", 2'h2, {pwr, susp})
        // Compliance events leave card detects alone
        far.plug(1'b1, 1'b1);
        far.pulse(0);
        far.pulse(0);
        `MSH_CHK("two devs", 1'b0, comp.devs)
        far.pulse(0);
        far.pulse(2);
        far.pulse(3);
        `MSH_CHK("comp", 3'h7, comp)
        rd_chk(`MSH_OFS_PORT, 32'h0000_01FD, "port");
        `MSH_CHK("cards", 2'h0, {cda_n, cdb_n})
        repeat (3) far.pulse(1);
        `MSH_CHK("comp clear", 3'h0, comp)
        far.pulse(4);
        `MSH_CHK("refused", 1'b1, cdb_n)
        cmd(`MSH_CMD_TUR, 8'h41, 8'h00);
        give_verdict();
    end
endmodule : tb_media_status_and_host_port_events
`default_nettype wire
